// >>> rtl/pfs_pkg.sv
// shared constants of the program flow sequencer
// assumes a single 40 MHz clock and a 32-bit program counter
package pfs_pkg;

  // ==========================================================
  // instruction codes and fields
  localparam logic [7:0] PFS_OP_COND_JUMP = 8'h15;
  localparam logic [7:0] PFS_OP_JUMP = 8'h16;
  localparam logic [7:0] PFS_OP_CALL = 8'h17;
  localparam logic [7:0] PFS_OP_RETURN = 8'h18;
  localparam logic [7:0] PFS_OP_WAIT = 8'h1B;
  localparam logic [7:0] PFS_COND_TIMEOUT = 8'h08;
  localparam logic [31:0] PFS_VALUE_FROM_ACC = 32'hFFFFFFFF;

  // ==========================================================
  // wait condition types
  localparam logic [7:0] PFS_WAIT_TICKS = 8'h00;
  localparam logic [7:0] PFS_WAIT_TARGET = 8'h01;
  localparam logic [7:0] PFS_WAIT_HOME_SW = 8'h02;
  localparam logic [7:0] PFS_WAIT_END_SW = 8'h03;
  localparam logic [7:0] PFS_WAIT_HOMING = 8'h04;

  // ==========================================================
  // sizes
  localparam int PFS_PC_W = 32;
  localparam int PFS_AXES = 6;
  localparam int PFS_STACK_DEPTH = 8;
  localparam int PFS_STACK_PTR_W = 4;

  // ==========================================================
  // timing: one tick is 10 ms
  localparam int PFS_CLK_HZ = 40_000_000;
  localparam int PFS_TICK_MS = 10;
  localparam int PFS_TICK_CYCLES = PFS_CLK_HZ / 1000 * PFS_TICK_MS;

  // ==========================================================
  // reset values
  localparam logic [31:0] PFS_PC_RESET = 32'h00000000;

  typedef enum logic [0:0] {
    PFS_ST_RUN = 1'b0,
    PFS_ST_WAIT = 1'b1
  } pfs_state_t;

endpackage : pfs_pkg

// >>> rtl/pfs_tick_div.sv
// tick divider: one-cycle pulse every TICK_CYCLES clocks
// assumes restart is a same-clock pulse that realigns the tick phase
`timescale 1ns/100ps
module pfs_tick_div #(
  parameter int TICK_CYCLES = 400000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  // tick
  output logic tick_q
);

  logic [31:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

endmodule : pfs_tick_div

// >>> rtl/pfs_ret_stack.sv
// return address stack, top entry held in a register
// assumes push is never asserted when full and pop never when empty
`timescale 1ns/100ps
module pfs_ret_stack
  import pfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operations
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic [PFS_PC_W-1:0] push_data,
  // state
  output logic [PFS_PC_W-1:0] top_q,
  output logic [PFS_STACK_PTR_W-1:0] count_q
);

  logic [PFS_PC_W-1:0] mem_q [PFS_STACK_DEPTH];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[count_q[2:0]] <= push_data;
    end
  end

  // top kept registered so a return needs no memory read cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      top_q <= PFS_PC_RESET;
    end else if (clear) begin
      count_q <= '0;
      top_q <= PFS_PC_RESET;
    end else if (push) begin
      count_q <= count_q + 4'h1;
      top_q <= push_data;
    end else if (pop) begin
      count_q <= count_q - 4'h1;
      top_q <= (count_q > 4'h1) ? mem_q[3'(count_q - 4'h2)] : PFS_PC_RESET;
    end
  end

endmodule : pfs_ret_stack

// >>> rtl/pfs_sequencer.sv
// program flow sequencer: jump, call, return and wait of a stored program
// assumes instruction fields come from program memory on this clock;
// axis status inputs are pins and get synchronised here.
//
// Notes on behaviour
// [RULE_01] code 22 loads the program counter from the value field
// [RULE_02] code 23 pushes the program counter, then loads the value field
// [RULE_03] the return stack holds eight entries, so calls nest eight deep
// [RULE_04] a call with a full stack is ignored; the counter just advances
// [RULE_05] code 24 pops the newest stack entry into the program counter
// [RULE_06] a return with an empty stack is ignored and execution continues
// [RULE_07] after a return execution resumes just after the matching call
// [RULE_08] code 27 picks a wait condition by type field, zero to four
// [RULE_09] while waiting the program counter stays on the wait instruction
// [RULE_10] type 0 waits until elapsed ticks equal the value field
// [RULE_11] type 1 waits for target reached on the selected axis
// [RULE_12] type 2 waits for the home switch of the selected axis
// [RULE_13] type 3 waits for either end switch of the selected axis
// [RULE_14] type 4 waits for homing done on the selected axis
// [RULE_15] types 1 to 4 take a tick timeout; zero means no timeout
// [RULE_16] a value of minus one takes the count from the accumulator
// [RULE_17] the program keeps the accumulator non-negative for such waits
// [RULE_18] an expired timeout sets the error flag until cleared
// [RULE_19] one tick is ten milliseconds
// [RULE_20] these instructions act only while a stored program runs
// [RULE_21] conditional jump type 8 branches when the timeout flag is set
// [RULE_22] starting a program empties the return stack
`timescale 1ns/100ps
module pfs_sequencer #(
  parameter int TICK_CYCLES = pfs_pkg::PFS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // program control
  input wire logic run_mode,
  input wire logic run_start,
  input wire logic [pfs_pkg::PFS_PC_W-1:0] start_addr,
  input wire logic err_clear,
  // instruction at the current program counter
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_type,
  input wire logic [7:0] instr_bank,
  input wire logic [31:0] instr_value,
  input wire logic [31:0] acc_in,
  // axis status pins
  input wire logic [pfs_pkg::PFS_AXES-1:0] axis_target_reached,
  input wire logic [pfs_pkg::PFS_AXES-1:0] axis_home_switch,
  input wire logic [pfs_pkg::PFS_AXES-1:0] axis_end_switch_left,
  input wire logic [pfs_pkg::PFS_AXES-1:0] axis_end_switch_right,
  input wire logic [pfs_pkg::PFS_AXES-1:0] axis_homing_done,
  // results
  output logic [pfs_pkg::PFS_PC_W-1:0] pc_q,
  output logic instr_done_q,
  output logic waiting_q,
  output logic timeout_error_flag_q,
  output logic [pfs_pkg::PFS_STACK_PTR_W-1:0] stack_depth_q
);
  import pfs_pkg::*;

  // ==========================================================
  // status pin synchronisers
  localparam int SYNC_W = 5 * PFS_AXES;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {axis_homing_done, axis_end_switch_right, axis_end_switch_left,
                  axis_home_switch, axis_target_reached};
      sync2_q <= sync1_q;
    end
  end

  logic [PFS_AXES-1:0] target_s;
  logic [PFS_AXES-1:0] home_s;
  logic [PFS_AXES-1:0] end_s;
  logic [PFS_AXES-1:0] homed_s;

  assign target_s = sync2_q[PFS_AXES-1:0];
  assign home_s = sync2_q[2*PFS_AXES-1:PFS_AXES];
  assign end_s = sync2_q[3*PFS_AXES-1:2*PFS_AXES] | sync2_q[4*PFS_AXES-1:3*PFS_AXES]; // RULE_13
  assign homed_s = sync2_q[5*PFS_AXES-1:4*PFS_AXES];

  // ==========================================================
  // instruction decode
  pfs_state_t state_q;
  logic take;
  logic is_call;
  logic is_ret;
  logic is_wait;
  logic stack_full;
  logic stack_empty;
  logic push;
  logic pop;
  logic [PFS_PC_W-1:0] stack_top;
  logic [PFS_PC_W-1:0] pc_next;

  // direct-mode commands reach this logic but take stays low without run_mode
  assign take = instr_valid && run_mode && !run_start && (state_q == PFS_ST_RUN); // RULE_20
  assign is_call = take && (instr_opcode == PFS_OP_CALL);
  assign is_ret = take && (instr_opcode == PFS_OP_RETURN);
  assign is_wait = take && (instr_opcode == PFS_OP_WAIT) && (instr_type <= PFS_WAIT_HOMING); // RULE_08
  assign stack_full = (stack_depth_q == 4'(PFS_STACK_DEPTH)); // RULE_03
  assign stack_empty = (stack_depth_q == '0);
  assign push = is_call && !stack_full; // RULE_02 RULE_04
  assign pop = is_ret && !stack_empty; // RULE_05 RULE_06
  assign pc_next = pc_q + 32'h00000001;

  pfs_ret_stack u_stack (
    .clk(clk),
    .rst(rst),
    .clear(run_start), // RULE_22
    .push(push),
    .pop(pop),
    .push_data(pc_q),
    .top_q(stack_top),
    .count_q(stack_depth_q)
  );

  // ==========================================================
  // wait bookkeeping
  logic [7:0] wait_type_q;
  logic [7:0] wait_bank_q;
  logic [31:0] wait_limit_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic cond_hit;
  logic limit_hit;
  logic wait_met;
  logic wait_tmo;

  pfs_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .restart(is_wait),
    .tick_q(tick)
  ); // RULE_19

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_type_q <= 8'h00;
      wait_bank_q <= 8'h00;
      wait_limit_q <= 32'h00000000;
    end else if (is_wait) begin
      wait_type_q <= instr_type;
      wait_bank_q <= instr_bank;
      wait_limit_q <= (instr_value == PFS_VALUE_FROM_ACC) ? acc_in : instr_value; // RULE_16
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h00000000;
    end else if (is_wait) begin
      tick_cnt_q <= 32'h00000000;
    end else if (state_q == PFS_ST_WAIT && tick) begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  // an axis number beyond the last axis never satisfies a condition
  always_comb begin
    cond_hit = 1'b0;
    if (wait_bank_q < 8'(PFS_AXES)) begin
      if (wait_type_q == PFS_WAIT_TARGET) begin
        cond_hit = target_s[wait_bank_q[2:0]]; // RULE_11
      end else if (wait_type_q == PFS_WAIT_HOME_SW) begin
        cond_hit = home_s[wait_bank_q[2:0]]; // RULE_12
      end else if (wait_type_q == PFS_WAIT_END_SW) begin
        cond_hit = end_s[wait_bank_q[2:0]]; // RULE_13
      end else if (wait_type_q == PFS_WAIT_HOMING) begin
        cond_hit = homed_s[wait_bank_q[2:0]]; // RULE_14
      end
    end
  end

  assign limit_hit = (tick_cnt_q == wait_limit_q);
  // the condition wins over a timeout that lands in the same cycle
  assign wait_met = (state_q == PFS_ST_WAIT) &&
                    ((wait_type_q == PFS_WAIT_TICKS) ? limit_hit : cond_hit); // RULE_10
  assign wait_tmo = (state_q == PFS_ST_WAIT) && (wait_type_q != PFS_WAIT_TICKS) &&
                    (wait_limit_q != 32'h00000000) && limit_hit && !cond_hit; // RULE_15

  // ==========================================================
  // program counter and sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PFS_ST_RUN;
      pc_q <= PFS_PC_RESET;
      instr_done_q <= 1'b0;
    end else begin
      instr_done_q <= 1'b0;
      if (run_start) begin
        state_q <= PFS_ST_RUN;
        pc_q <= start_addr;
      end else if (state_q == PFS_ST_WAIT) begin
        // program counter held on the wait instruction meanwhile
        if (!run_mode) begin
          state_q <= PFS_ST_RUN;
        end else if (wait_met || wait_tmo) begin
          state_q <= PFS_ST_RUN;
          pc_q <= pc_next;
          instr_done_q <= 1'b1;
        end // RULE_09
      end else if (take) begin
        instr_done_q <= !is_wait;
        if (is_wait) begin
          state_q <= PFS_ST_WAIT;
        end else if (instr_opcode == PFS_OP_JUMP) begin
          pc_q <= instr_value; // RULE_01
        end else if (push) begin
          pc_q <= instr_value; // RULE_02
        end else if (pop) begin
          pc_q <= stack_top + 32'h00000001; // RULE_07
        end else if (instr_opcode == PFS_OP_COND_JUMP && instr_type == PFS_COND_TIMEOUT &&
                     timeout_error_flag_q) begin
          pc_q <= instr_value; // RULE_21
        end else begin
          pc_q <= pc_next;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waiting_q <= 1'b0;
    end else begin
      waiting_q <= is_wait || (waiting_q && run_mode && !run_start && !wait_met && !wait_tmo);
    end
  end

  // setting beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_error_flag_q <= 1'b0;
    end else if (wait_tmo && run_mode && !run_start) begin
      timeout_error_flag_q <= 1'b1; // RULE_18
    end else if (err_clear) begin
      timeout_error_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  jump_load_a: assert property (@(posedge clk) disable iff (rst) // RULE_01
    take && instr_opcode == PFS_OP_JUMP |=> pc_q == $past(instr_value) && instr_done_q)
    else $error("jump did not load the program counter");

  call_push_a: assert property (@(posedge clk) disable iff (rst) // RULE_02
    push |=> pc_q == $past(instr_value) && stack_top == $past(pc_q) &&
             stack_depth_q == $past(stack_depth_q) + 4'h1)
    else $error("call did not push and load");

  call_full_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
    is_call && stack_full |=> pc_q == $past(pc_q) + 32'h00000001 && stack_depth_q == 4'h8)
    else $error("call on full stack was not ignored");

  stack_depth_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
    stack_depth_q <= 4'h8)
    else $error("return stack deeper than eight");

  ret_pop_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
    pop |=> pc_q == $past(stack_top) + 32'h00000001 &&
            stack_depth_q == $past(stack_depth_q) - 4'h1)
    else $error("return did not resume after the call");

  ret_empty_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
    is_ret && stack_empty |=> pc_q == $past(pc_q) + 32'h00000001 && instr_done_q)
    else $error("return on empty stack was not ignored");

  wait_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
    state_q == PFS_ST_WAIT && !wait_met && !wait_tmo && !run_start |=> $stable(pc_q))
    else $error("program counter moved during a wait");

  tick_wait_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
    state_q == PFS_ST_WAIT && wait_type_q == PFS_WAIT_TICKS && tick_cnt_q == wait_limit_q &&
    run_mode && !run_start |=> instr_done_q && !waiting_q && pc_q == $past(pc_q) + 32'h00000001)
    else $error("tick wait ended at the wrong count");

  timeout_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE_18
    wait_tmo && run_mode && !run_start |=> timeout_error_flag_q && !waiting_q && instr_done_q)
    else $error("timeout did not set the error flag");

  no_timeout_a: assert property (@(posedge clk) disable iff (rst) // RULE_15
    state_q == PFS_ST_WAIT && wait_limit_q == 32'h00000000 && wait_type_q != PFS_WAIT_TICKS
    |=> !$rose(timeout_error_flag_q))
    else $error("zero timeout expired");

  direct_ignore_a: assert property (@(posedge clk) disable iff (rst) // RULE_20
    instr_valid && !run_mode && !run_start && state_q == PFS_ST_RUN |=> $stable(pc_q) && !instr_done_q)
    else $error("instruction acted outside program execution");

  start_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE_22
    run_start |=> stack_depth_q == 4'h0 && pc_q == $past(start_addr))
    else $error("program start did not empty the stack");

  wait_enter_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
    is_wait |=> waiting_q && state_q == PFS_ST_WAIT && $stable(pc_q) && !instr_done_q)
    else $error("wait was not entered");

  bad_type_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
    take && instr_opcode == PFS_OP_WAIT && instr_type > PFS_WAIT_HOMING
    |=> pc_q == $past(pc_q) + 32'h00000001 && instr_done_q && !waiting_q)
    else $error("wait with unknown type did not just advance");

  acc_limit_a: assert property (@(posedge clk) disable iff (rst) // RULE_16
    is_wait && instr_value == PFS_VALUE_FROM_ACC |=> wait_limit_q == $past(acc_in))
    else $error("wait did not take its count from the accumulator");

  target_end_a: assert property (@(posedge clk) disable iff (rst) // RULE_11
    state_q == PFS_ST_WAIT && run_mode && !run_start && wait_type_q == PFS_WAIT_TARGET &&
    wait_bank_q < 8'h06 && target_s[wait_bank_q[2:0]] |=> instr_done_q && !waiting_q)
    else $error("target reached did not end the wait");

  cond_jump_a: assert property (@(posedge clk) disable iff (rst) // RULE_21
    take && instr_opcode == PFS_OP_COND_JUMP && instr_type == PFS_COND_TIMEOUT
    |=> pc_q == ($past(timeout_error_flag_q) ? $past(instr_value) : $past(pc_q) + 32'h00000001))
    else $error("timeout branch went the wrong way");

  flag_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE_18
    err_clear && !wait_tmo |=> !timeout_error_flag_q)
    else $error("clear did not drop the timeout flag");

  // the count may only move on a tick, or the wait length drifts
  tick_step_a: assert property (@(posedge clk) disable iff (rst) // RULE_19
    state_q == PFS_ST_WAIT && !tick |=> $stable(tick_cnt_q))
    else $error("tick count moved without a tick");

endmodule : pfs_sequencer

// >>> tb/pfs_axis_model.sv
// axis status model standing in for the motion side of the sequencer
// assumes arm is a one-cycle pulse from the bench; kind, axis, delay and use_right stay put until the next arm
`timescale 1ns/100ps
module pfs_axis_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control from the bench
  input wire logic arm,
  input wire logic [2:0] kind,
  input wire logic [2:0] axis,
  input wire logic [15:0] delay,
  input wire logic use_right,
  // status pins
  output logic [5:0] target_reached,
  output logic [5:0] home_switch,
  output logic [5:0] end_left,
  output logic [5:0] end_right,
  output logic [5:0] homing_done
);
  logic [15:0] cnt_q;
  logic [5:0] sel;
  logic [5:0] armed_v;
  // ==========================================================
  // delay counter, restarted by arm, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (arm) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // ==========================================================
  // every bit but the awaited one stays high, so a wrong axis or kind ends a wait early
  assign sel = 6'h01 << axis;
  assign armed_v = ~sel | ((cnt_q >= delay) ? sel : 6'h00);
  assign target_reached = (kind == 3'h1) ? armed_v : 6'h3F;
  assign home_switch = (kind == 3'h2) ? armed_v : 6'h3F;
  assign end_left = (kind == 3'h3) ? (use_right ? ~sel : armed_v) : 6'h3F;
  assign end_right = (kind == 3'h3) ? (use_right ? armed_v : ~sel) : 6'h3F;
  assign homing_done = (kind == 3'h4) ? armed_v : 6'h3F;
endmodule : pfs_axis_model

// >>> tb/tb_top.sv
// self-checking bench for the program flow sequencer
// assumes the sequencer runs with a 4-cycle tick so waits stay short
`timescale 1ns/100ps
module tb_top;
  import pfs_pkg::*;
  localparam int TK = 4;
  localparam logic [7:0] DIRECT_OPS [4] = '{PFS_OP_JUMP, PFS_OP_CALL, PFS_OP_RETURN, PFS_OP_WAIT};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run_mode = 1'b0, run_start = 1'b0, err_clear = 1'b0, instr_valid = 1'b0, arm = 1'b0, use_right = 1'b0;
  logic [31:0] start_addr = 32'h00000000, acc_in = 32'h00000000, instr_value = 32'h00000000;
  logic [7:0] instr_opcode = 8'h00, instr_type = 8'h00, instr_bank = 8'h00;
  logic [2:0] kind = 3'h0, axis = 3'h0;
  logic [15:0] delay = 16'h0000;
  logic [5:0] tr, hs, el, er, hd;
  logic [31:0] pc_q, p, v, s;
  logic [31:0] rets [8];
  logic instr_done_q, waiting_q, timeout_error_flag_q;
  logic [3:0] stack_depth_q;
  int fail_count = 0, n_checks = 0, seed = 16, cyc, a, d;

  always #12.5 clk = ~clk;

  pfs_sequencer #(.TICK_CYCLES(TK)) dut_u (
    .clk(clk), .rst(rst), .run_mode(run_mode), .run_start(run_start), .start_addr(start_addr),
    .err_clear(err_clear), .instr_valid(instr_valid), .instr_opcode(instr_opcode), .instr_type(instr_type),
    .instr_bank(instr_bank), .instr_value(instr_value), .acc_in(acc_in), .axis_target_reached(tr),
    .axis_home_switch(hs), .axis_end_switch_left(el), .axis_end_switch_right(er), .axis_homing_done(hd),
    .pc_q(pc_q), .instr_done_q(instr_done_q), .waiting_q(waiting_q),
    .timeout_error_flag_q(timeout_error_flag_q), .stack_depth_q(stack_depth_q));

  pfs_axis_model model_u (
    .clk(clk), .rst(rst), .arm(arm), .kind(kind), .axis(axis), .delay(delay), .use_right(use_right),
    .target_reached(tr), .home_switch(hs), .end_left(el), .end_right(er), .homing_done(hd));

  // ==========================================================
  // helpers
  function automatic logic tick_ok(input int c, input int n);
    return c >= n * TK + 1 && c <= n * TK + 3;
  endfunction : tick_ok

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // one instruction, valid for exactly one edge; cyc is 1 when done follows the taking edge itself
  task automatic exec(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk, input logic [31:0] val,
      input int lim);
    logic [31:0] p0;
    @(posedge clk);
    instr_opcode <= op;
    instr_type <= ty;
    instr_bank <= bk;
    instr_value <= val;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    p0 = pc_q;
    cyc = 1;
    // done stands for one cycle only, so look right after the taking edge
    #1;
    while (instr_done_q !== 1'b1 && cyc < lim) begin
      if (pc_q !== p0) chk("pc held", p0, pc_q);
      if (op == PFS_OP_WAIT && run_mode && waiting_q !== 1'b1) chk("waiting", 32'd1, waiting_q);
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask : exec

  task automatic start_prog(input logic [31:0] addr);
    @(posedge clk);
    start_addr <= addr;
    run_start <= 1'b1;
    @(posedge clk);
    run_start <= 1'b0;
    #1;
  endtask : start_prog

  // the model needs a few cycles so the synchronisers flush the previous status
  task automatic arm_axis(input logic [2:0] k, input logic [2:0] ax, input logic [15:0] dl, input logic r);
    @(posedge clk);
    kind <= k;
    axis <= ax;
    delay <= dl;
    use_right <= r;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : arm_axis

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    $display("Error watchdog expected finish seen hang");
    fail_count++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk("pc reset", PFS_PC_RESET, pc_q);
    chk("outs reset", 32'h0, {25'h0, instr_done_q, waiting_q, timeout_error_flag_q, stack_depth_q});
    foreach (DIRECT_OPS[i]) begin
      exec(DIRECT_OPS[i], 8'h00, 8'h00, 32'h00000040, 4);
      chk("direct pc", 32'h0, pc_q);
      chk("direct done", 32'h0, {instr_done_q, stack_depth_q});
    end
    $display("test direct done");
    @(posedge clk);
    run_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      exec(PFS_OP_JUMP, 8'($random(seed)), 8'($random(seed)), v, 8);
      chk("jump pc", v, pc_q);
      chk("jump span", 32'd1, cyc);
    end
    $display("test jump done");
    s = {16'h0000, 16'($random(seed))};
    start_prog(s);
    chk("start pc", s, pc_q);
    for (int i = 0; i < 8; i++) begin
      rets[i] = pc_q;
      v = {16'h0001, 16'($random(seed))};
      exec(PFS_OP_CALL, 8'h00, 8'($random(seed)), v, 8);
      chk("call pc", v, pc_q);
      chk("call depth", i + 1, stack_depth_q);
    end
    p = pc_q;
    exec(PFS_OP_CALL, 8'h00, 8'h00, 32'h00000055, 8);
    chk("full call pc", p + 1, pc_q);
    chk("full call depth", 32'd8, stack_depth_q);
    for (int i = 7; i >= 0; i--) begin
      exec(PFS_OP_RETURN, 8'($random(seed)), 8'($random(seed)), $random(seed), 8);
      chk("return pc", rets[i] + 1, pc_q);
      chk("return depth", i, stack_depth_q);
    end
    p = pc_q;
    exec(PFS_OP_RETURN, 8'h00, 8'h00, 32'h0, 8);
    chk("empty return pc", p + 1, pc_q);
    exec(PFS_OP_CALL, 8'h00, 8'h00, 32'h00000200, 8);
    start_prog(s);
    chk("start depth", 32'd0, stack_depth_q);
    exec(PFS_OP_RETURN, 8'h00, 8'h00, 32'h0, 8);
    chk("start return pc", s + 1, pc_q);
    $display("test stack done");
    for (int n = 0; n < 4; n++) begin
      @(posedge clk);
      acc_in <= n;
      p = pc_q;
      exec(PFS_OP_WAIT, PFS_WAIT_TICKS, 8'($random(seed)), (n == 2) ? PFS_VALUE_FROM_ACC : 32'(n), 40);
      chk("tick span", 32'd1, tick_ok(cyc, n));
      chk("tick pc", p + 1, pc_q);
      chk("tick waiting", 32'd0, waiting_q);
    end
    $display("test ticks done");
    for (int k = 1; k < 5; k++) begin
      a = {$random(seed)} % 6;
      d = 10 + {$random(seed)} % 16;
      arm_axis(3'(k), 3'(a), 16'(d), 1'($random(seed)));
      p = pc_q;
      exec(PFS_OP_WAIT, 8'(k), 8'(a), (k == 2) ? 32'd500 : 32'd0, 60);
      chk("cond span", 32'd1, cyc >= d - 4 && cyc <= d + 1);
      chk("cond pc", p + 1, pc_q);
      chk("cond flag", 32'd0, timeout_error_flag_q);
    end
    p = pc_q;
    exec(PFS_OP_WAIT, 8'h05, 8'h00, 32'h0, 8);
    chk("bad type pc", p + 1, pc_q);
    chk("bad type span", 32'd1, cyc);
    $display("test conditions done");
    arm_axis(3'h3, 3'h2, 16'hFFFF, 1'b0);
    @(posedge clk);
    acc_in <= 32'd2;
    p = pc_q;
    exec(PFS_OP_WAIT, PFS_WAIT_END_SW, 8'h02, PFS_VALUE_FROM_ACC, 40);
    chk("timeout span", 32'd1, tick_ok(cyc, 2));
    chk("timeout pc", p + 1, pc_q);
    chk("timeout flag", 32'd1, timeout_error_flag_q);
    v = {16'h0002, 16'($random(seed))};
    exec(PFS_OP_JUMP, 8'h00, 8'h00, v + 32'h100, 8);
    chk("flag sticky", 32'd1, timeout_error_flag_q);
    exec(PFS_OP_COND_JUMP, PFS_COND_TIMEOUT, 8'h00, v, 8);
    chk("cond jump taken", v, pc_q);
    p = pc_q;
    exec(PFS_OP_COND_JUMP, 8'h00, 8'h00, v + 32'h300, 8);
    chk("cond jump other", p + 1, pc_q);
    @(posedge clk);
    err_clear <= 1'b1;
    @(posedge clk);
    err_clear <= 1'b0;
    #1;
    chk("flag cleared", 32'd0, timeout_error_flag_q);
    p = pc_q;
    exec(PFS_OP_COND_JUMP, PFS_COND_TIMEOUT, 8'h00, v, 8);
    chk("cond jump skipped", p + 1, pc_q);
    // every target pin is high here, yet axis six does not exist
    exec(PFS_OP_WAIT, PFS_WAIT_TARGET, 8'h06, 32'd1, 40);
    chk("bank range span", 32'd1, tick_ok(cyc, 1));
    chk("bank range flag", 32'd1, timeout_error_flag_q);
    $display("test timeout done");
    end_sim();
  end
endmodule : tb_top
